//--- verilog/hdp_defs.svh
// constants of the headend downstream profile scheduler
// assumes one receive clock and a synchronous active-high reset
`ifndef HDP_DEFS_SVH
`define HDP_DEFS_SVH

`define HDP_PROF_W 2
`define HDP_MASK_W 4
`define HDP_MODEM_W 2
`define HDP_CHAN_W 1
`define HDP_SID_W 4
`define HDP_ENT_W 3
`define HDP_MAP_AW 5
`define HDP_CNT_W 16

`define HDP_PROF_COMMON 2'h0
`define HDP_PROF_NEXT1 2'h1
`define HDP_PROF_NEXT2 2'h2
`define HDP_PROF_NEXT3 2'h3

`define HDP_MASK_RST 4'h1
`define HDP_MASK_NONE 4'h0
`define HDP_MASK_ONE 4'h1
`define HDP_CNT_ONE 16'h0001
`define HDP_CNT_RST 16'h0000

`endif

//--- verilog/hdp_pkg.sv
// types of the headend downstream profile scheduler
// assumes hdp_defs.svh is on the include path
`include "hdp_defs.svh"
package hdp_pkg;

  // =========================================================
  // message kinds
  typedef enum logic [2:0] {
    k_data,
    k_mgmt_uc,
    k_mgmt_bc,
    k_chan_desc,
    k_prof_desc
  } hdp_kind_t;

  // =========================================================
  // carriers
  typedef struct packed {
    hdp_kind_t kind;
    logic [`HDP_MODEM_W-1:0] modem;
    logic [`HDP_CHAN_W-1:0] chan;
    logic [`HDP_SID_W-1:0] sid;
    logic [`HDP_PROF_W-1:0] desc;
  } hdp_req_t;

  typedef struct packed {
    logic [`HDP_MODEM_W-1:0] modem;
    logic [`HDP_CHAN_W-1:0] chan;
    logic [`HDP_MASK_W-1:0] mask;
    logic trans_valid;
    logic [`HDP_PROF_W-1:0] trans_id;
  } hdp_asg_t;

  typedef struct packed {
    logic [`HDP_SID_W-1:0] sid;
    logic [`HDP_CHAN_W-1:0] chan;
    logic [`HDP_PROF_W-1:0] prof;
  } hdp_map_t;

  typedef struct packed {
    hdp_kind_t kind;
    logic phy_link_channel;
    logic [`HDP_MODEM_W-1:0] modem;
    logic [`HDP_CHAN_W-1:0] chan;
    logic [`HDP_PROF_W-1:0] prof;
    logic [`HDP_PROF_W-1:0] desc;
  } hdp_tx_t;

endpackage

//--- verilog/hdp_mem.sv
// small memory holding the stream-to-profile map
// assumes one clock; read data come out of a register one cycle later
module hdp_mem #(
  parameter int W = 2,
  parameter int AW = 5
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);

  logic [W-1:0] mem_q [(1 << AW)-1:0];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule

//--- verilog/hdp_sched.sv
// headend side downstream profile scheduler: picks the profile and the
// phy link channel copy for every outgoing message
// assumes requests, assignments and map writes are synchronous to clk_i
`include "hdp_defs.svh"
module hdp_sched (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire hdp_pkg::hdp_req_t req_i,
  output logic req_ready_o,
  input wire logic asg_we_i,
  input wire hdp_pkg::hdp_asg_t asg_i,
  input wire logic map_we_i,
  input wire hdp_pkg::hdp_map_t map_i,
  output logic tx_valid_o,
  output hdp_pkg::hdp_tx_t tx_o,
  output logic drop_o,
  output logic [`HDP_CNT_W-1:0] drop_cnt_o
);

  localparam int NENT = 1 << `HDP_ENT_W;
  localparam int NMAP = 1 << `HDP_MAP_AW;

  typedef enum logic [1:0] {
    st_idle,
    st_look,
    st_dup
  } hdp_state_t;

  // =========================================================
  // functions
  function automatic logic [`HDP_ENT_W-1:0] ent(
    input logic [`HDP_MODEM_W-1:0] m,
    input logic [`HDP_CHAN_W-1:0] c
  );
    return {m, c};
  endfunction

  function automatic logic [`HDP_PROF_W-1:0] first_prof(
    input logic [`HDP_MASK_W-1:0] m
  );
    logic [`HDP_PROF_W-1:0] p;
    p = `HDP_PROF_COMMON;
    for (int i = `HDP_MASK_W - 1; i >= 0; i--)
    begin
      if (m[i])
      begin
        p = `HDP_PROF_W'(i);
      end
    end
    return p;
  endfunction

  function automatic logic [`HDP_MASK_W-1:0] bit_of(
    input logic [`HDP_PROF_W-1:0] p
  );
    return `HDP_MASK_W'(`HDP_MASK_ONE << p);
  endfunction

  // =========================================================
  // state
  hdp_state_t state_q;
  hdp_state_t state_d;
  hdp_pkg::hdp_req_t req_q;
  hdp_pkg::hdp_tx_t tx_d;
  logic tx_valid_d;
  logic drop_d;
  logic ready_q;
  logic [NENT-1:0][`HDP_MASK_W-1:0] mask_q;
  logic [NENT-1:0] tvld_q;
  logic [NENT-1:0][`HDP_PROF_W-1:0] tid_q;
  logic [NMAP-1:0] mapped_q;
  logic [`HDP_CNT_W-1:0] drop_cnt_q;
  logic [`HDP_PROF_W-1:0] map_rdata;

  // =========================================================
  // assignment copy per modem and channel
  genvar g;
  generate
    for (g = 0; g < NENT; g++)
    begin : g_ent
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          mask_q[g] <= `HDP_MASK_RST;
          tvld_q[g] <= 1'b0;
          tid_q[g] <= `HDP_PROF_COMMON;
        end
        else if (asg_we_i && ent(asg_i.modem, asg_i.chan) == g)
        begin
          mask_q[g] <= asg_i.mask;
          tvld_q[g] <= asg_i.trans_valid;
          tid_q[g] <= asg_i.trans_id;
        end
      end
    end
  endgenerate

  // =========================================================
  // stream to profile map
  wire accept = req_valid_i && ready_q;
  wire [`HDP_MAP_AW-1:0] map_waddr = {map_i.sid, map_i.chan};
  wire [`HDP_MAP_AW-1:0] map_raddr = accept ? {req_i.sid, req_i.chan}
                                            : {req_q.sid, req_q.chan};

  hdp_mem #(
    .W(`HDP_PROF_W),
    .AW(`HDP_MAP_AW)
  ) u_map (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(map_we_i),
    .waddr_i(map_waddr),
    .wdata_i(map_i.prof),
    .raddr_i(map_raddr),
    .rdata_o(map_rdata)
  );

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mapped_q <= '0;
    end
    else if (map_we_i)
    begin
      mapped_q[map_waddr] <= 1'b1;
    end
  end

  // =========================================================
  // profile decision
  wire [`HDP_ENT_W-1:0] ri = ent(req_q.modem, req_q.chan);
  wire [`HDP_MASK_W-1:0] excl = tvld_q[ri] ? bit_of(tid_q[ri])
                                           : `HDP_MASK_NONE;
  // transition profile is never a target for traffic
  wire [`HDP_MASK_W-1:0] recv = mask_q[ri] & ~excl;
  wire map_hit = mapped_q[{req_q.sid, req_q.chan}];
  // one profile per stream id and channel, so every flow on it agrees
  wire [`HDP_PROF_W-1:0] data_prof = map_hit ? map_rdata
                                             : `HDP_PROF_COMMON;
  wire data_ok = recv[data_prof];
  wire uc_ok = |recv;
  wire [`HDP_PROF_W-1:0] uc_prof = first_prof(recv);
  wire is_data = req_q.kind == hdp_pkg::k_data;
  wire is_uc = req_q.kind == hdp_pkg::k_mgmt_uc;
  wire is_cd = req_q.kind == hdp_pkg::k_chan_desc;
  wire is_pd = req_q.kind == hdp_pkg::k_prof_desc;
  wire look_drop = (is_data && !data_ok) || (is_uc && !uc_ok);
  // channel descriptor twice; profile descriptor of the common one twice
  wire look_dup = is_cd || (is_pd && req_q.desc == `HDP_PROF_COMMON);
  wire [`HDP_PROF_W-1:0] look_prof = is_data ? data_prof
                                   : is_uc ? uc_prof
                                   : `HDP_PROF_COMMON;

  always_comb
  begin
    state_d = state_q;
    tx_d = tx_o;
    tx_valid_d = 1'b0;
    drop_d = 1'b0;
    unique case (state_q)
      st_idle:
      begin
        if (accept)
        begin
          state_d = st_look;
        end
      end
      st_look:
      begin
        tx_d.kind = req_q.kind;
        tx_d.modem = req_q.modem;
        tx_d.chan = req_q.chan;
        tx_d.desc = req_q.desc;
        tx_d.prof = look_prof;
        tx_d.phy_link_channel = is_cd;
        tx_valid_d = !look_drop;
        drop_d = look_drop;
        state_d = (look_dup && !look_drop) ? st_dup : st_idle;
      end
      st_dup:
      begin
        // second copy swaps between phy link channel and common profile
        tx_d.phy_link_channel = !tx_o.phy_link_channel;
        tx_d.prof = `HDP_PROF_COMMON;
        tx_valid_d = 1'b1;
        state_d = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= st_idle;
      ready_q <= 1'b1;
      req_q <= '0;
      tx_o <= '0;
      tx_valid_o <= 1'b0;
      drop_o <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ready_q <= state_d == st_idle;
      if (accept)
      begin
        req_q <= req_i;
      end
      tx_o <= tx_d;
      tx_valid_o <= tx_valid_d;
      drop_o <= drop_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      drop_cnt_q <= `HDP_CNT_RST;
    end
    else if (drop_d)
    begin
      drop_cnt_q <= drop_cnt_q + `HDP_CNT_ONE;
    end
  end

  assign req_ready_o = ready_q;
  assign drop_cnt_o = drop_cnt_q;

  // =========================================================
  // checks
  wire [`HDP_ENT_W-1:0] ti = ent(tx_o.modem, tx_o.chan);
  wire tx_data = tx_valid_o && tx_o.kind == hdp_pkg::k_data;
  wire tx_uc = tx_valid_o && tx_o.kind == hdp_pkg::k_mgmt_uc;

  property p_no_trans;
    @(posedge clk_i) disable iff (sys_rst_i)
      tx_data && !$past(asg_we_i) |->
        !(tvld_q[ti] && tid_q[ti] == tx_o.prof);
  endproperty
  a_no_trans: assert property (p_no_trans)
    else $error("data sent on transition profile");

  property p_uc_recv;
    @(posedge clk_i) disable iff (sys_rst_i)
      (tx_uc || tx_data) && !$past(asg_we_i) |->
        mask_q[ti][tx_o.prof];
  endproperty
  a_uc_recv: assert property (p_uc_recv)
    else $error("message on profile the modem does not receive");

  property p_bc_common;
    @(posedge clk_i) disable iff (sys_rst_i)
      tx_valid_o && tx_o.kind == hdp_pkg::k_mgmt_bc |->
        tx_o.prof == `HDP_PROF_COMMON && !tx_o.phy_link_channel
        ##1 !(tx_valid_o && tx_o.kind == hdp_pkg::k_mgmt_bc);
  endproperty
  a_bc_common: assert property (p_bc_common)
    else $error("broadcast message not single on common profile");

  property p_cd_pair;
    @(posedge clk_i) disable iff (sys_rst_i)
      tx_valid_o && tx_o.kind == hdp_pkg::k_chan_desc && tx_o.phy_link_channel |=>
        tx_valid_o && tx_o.kind == hdp_pkg::k_chan_desc && !tx_o.phy_link_channel &&
        tx_o.prof == `HDP_PROF_COMMON && $stable(tx_o.chan);
  endproperty
  a_cd_pair: assert property (p_cd_pair)
    else $error("channel descriptor not repeated on common profile");

  property p_pd_common;
    @(posedge clk_i) disable iff (sys_rst_i)
      tx_valid_o && tx_o.kind == hdp_pkg::k_prof_desc && !tx_o.phy_link_channel |->
        tx_o.prof == `HDP_PROF_COMMON;
  endproperty
  a_pd_common: assert property (p_pd_common)
    else $error("profile descriptor off the common profile");

  property p_pd_plc;
    @(posedge clk_i) disable iff (sys_rst_i)
      tx_valid_o && tx_o.kind == hdp_pkg::k_prof_desc && tx_o.phy_link_channel |->
        tx_o.desc == `HDP_PROF_COMMON && $past(tx_valid_o) &&
        !$past(tx_o.phy_link_channel);
  endproperty
  a_pd_plc: assert property (p_pd_plc)
    else $error("wrong profile descriptor on phy link channel");

  property p_stream;
    @(posedge clk_i) disable iff (sys_rst_i)
      state_q == st_look && is_data && map_hit && data_ok |=>
        tx_valid_o && tx_o.prof == $past(map_rdata);
  endproperty
  a_stream: assert property (p_stream)
    else $error("stream sent off its mapped profile");

  property p_answer;
    @(posedge clk_i) disable iff (sys_rst_i)
      accept |=> !req_ready_o ##[1:2] (tx_valid_o || drop_o);
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered in time");

  property p_rst_common;
    @(posedge clk_i)
      $past(sys_rst_i) && !sys_rst_i |-> mask_q[0] == `HDP_MASK_RST;
  endproperty
  a_rst_common: assert property (p_rst_common)
    else $error("assignment not common profile after reset");

endmodule

//--- verification/hdp_modem_model.sv
// modem model: keeps the assigned set per modem and channel and judges
// every data emission of the scheduler
// assumes the scheduler's tx and assignment ports share one clock
`include "hdp_defs.svh"
module hdp_modem_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic asg_we_i,
  input wire hdp_pkg::hdp_asg_t asg_i,
  input wire logic tx_valid_i,
  input wire hdp_pkg::hdp_tx_t tx_i,
  output logic [15:0] fwd_o,
  output logic [15:0] bad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mask [8];
  logic [2:0] trans [8];
  logic [2:0] ix;
  logic [3:0] m;
  assign ix = {tx_i.modem, tx_i.chan};
  assign m = mask[ix];
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      foreach (mask[i]) mask[i] <= `HDP_MASK_RST;
      foreach (trans[i]) trans[i] <= 3'h0;
      fwd_o <= 16'h0000;
      bad_o <= 16'h0000;
    end
    else
    begin
      if (asg_we_i)
      begin
        mask[{asg_i.modem, asg_i.chan}] <= asg_i.mask;
        // transition id kept to judge data sent on the transition profile
        trans[{asg_i.modem, asg_i.chan}] <=
          {asg_i.trans_valid, asg_i.trans_id};
      end
      if (tx_valid_i && !tx_i.phy_link_channel && tx_i.kind == hdp_pkg::k_data)
      begin
        // transition profile never carries traffic
        if (m[tx_i.prof] && trans[ix] != {1'b1, tx_i.prof})
          fwd_o <= fwd_o + 16'h0001;
        else
          bad_o <= bad_o + 16'h0001;
      end
    end
  end
endmodule

//--- verification/downstream_profile_filter_bench.sv
// bench for the downstream profile scheduler with a modem model
// assumes hdp_defs.svh on the include path and hdp_pkg compiled first
`include "hdp_defs.svh"
module downstream_profile_filter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  hdp_pkg::hdp_req_t req = '0;
  logic ready;
  logic asg_we = 1'b0;
  hdp_pkg::hdp_asg_t asg = '0;
  logic map_we = 1'b0;
  hdp_pkg::hdp_map_t mp = '0;
  logic tx_valid;
  hdp_pkg::hdp_tx_t tx;
  logic drop;
  logic [`HDP_CNT_W-1:0] drop_cnt;
  logic [15:0] fwd;
  logic [15:0] bad;
  int err_total = 0;
  int compares = 0;
  int n_tx;
  int n_drop;
  hdp_pkg::hdp_kind_t kind_x;
  hdp_pkg::hdp_tx_t tx_q [2];

  always #2 clk = ~clk;

  hdp_sched dut_u (.clk_i(clk), .sys_rst_i(rst), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(ready), .asg_we_i(asg_we), .asg_i(asg),
    .map_we_i(map_we), .map_i(mp), .tx_valid_o(tx_valid), .tx_o(tx),
    .drop_o(drop), .drop_cnt_o(drop_cnt));
  hdp_modem_model model_u (.clk_i(clk), .sys_rst_i(rst), .asg_we_i(asg_we),
    .asg_i(asg), .tx_valid_i(tx_valid), .tx_i(tx), .fwd_o(fwd), .bad_o(bad));

  // ==========================================================
  // shared tasks
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cfg(logic [3:0] m, logic tv, logic [1:0] ti,
    logic [3:0] s, logic [1:0] p);
    @(posedge clk);
    asg_we <= 1'b1;
    asg <= '{modem: 2'h1, chan: 1'h0, mask: m, trans_valid: tv,
      trans_id: ti};
    map_we <= 1'b1;
    mp <= '{sid: s, chan: 1'h0, prof: p};
    @(posedge clk);
    asg_we <= 1'b0;
    map_we <= 1'b0;
  endtask

  // drives one request and gathers the emissions that follow it
  task automatic send(hdp_pkg::hdp_kind_t k, logic [3:0] s, logic [1:0] d,
    logic c = 1'h0);
    n_tx = 0;
    n_drop = 0;
    kind_x = k;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{kind: k, modem: 2'h1, chan: c, sid: s, desc: d};
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chk("ready after take", 16'(ready), 16'h0000);
    repeat (4)
    begin
      @(negedge clk);
      if (tx_valid === 1'b1 && n_tx < 2)
        tx_q[n_tx] = tx;
      if (tx_valid === 1'b1)
        n_tx++;
      if (drop === 1'b1)
        n_drop++;
    end
    chk("ready after answer", 16'(ready), 16'h0001);
  endtask

  task automatic tx_is(int i, logic pl, logic [1:0] p);
    chk("tx plc", 16'(tx_q[i].phy_link_channel), 16'(pl));
    chk("tx prof", 16'(tx_q[i].prof), 16'(p));
    chk("tx kind", 16'(tx_q[i].kind), 16'(kind_x));
    chk("tx modem", 16'(tx_q[i].modem), 16'h0001);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    @(negedge clk);
    chk("ready idle", 16'(ready), 16'h0001);
    chk("tx idle", 16'(tx_valid), 16'h0000);
    chk("drop count", drop_cnt, 16'h0000);
    send(hdp_pkg::k_data, 4'h5, 2'h0);
    chk("tx count", 16'(n_tx), 16'h0001);
    tx_is(0, 1'b0, `HDP_PROF_COMMON);
  endtask

  task automatic t_profiles;
    for (int p = 1; p < 4; p++)
    begin
      cfg(4'hf, 1'b0, 2'h0, 4'(p + 8), 2'(p));
      send(hdp_pkg::k_data, 4'(p + 8), 2'h0);
      chk("tx count", 16'(n_tx), 16'h0001);
      tx_is(0, 1'b0, 2'(p));
    end
  endtask

  task automatic t_refuse;
    cfg(4'h3, 1'b1, `HDP_PROF_NEXT1, 4'h2, `HDP_PROF_NEXT1);
    send(hdp_pkg::k_data, 4'h2, 2'h0);
    chk("drop on transition", 16'(n_drop), 16'h0001);
    chk("no tx on transition", 16'(n_tx), 16'h0000);
    cfg(4'h1, 1'b0, 2'h0, 4'h3, `HDP_PROF_NEXT3);
    send(hdp_pkg::k_data, 4'h3, 2'h0);
    chk("drop unassigned", 16'(n_drop), 16'h0001);
    chk("drop count", drop_cnt, 16'h0002);
  endtask

  task automatic t_mgmt;
    cfg(4'hc, 1'b1, `HDP_PROF_NEXT2, 4'h0, 2'h0);
    send(hdp_pkg::k_mgmt_uc, 4'h0, 2'h0);
    tx_is(0, 1'b0, `HDP_PROF_NEXT3);
    send(hdp_pkg::k_mgmt_bc, 4'h0, 2'h0);
    chk("single broadcast", 16'(n_tx), 16'h0001);
    tx_is(0, 1'b0, `HDP_PROF_COMMON);
    cfg(4'h4, 1'b1, `HDP_PROF_NEXT2, 4'h0, 2'h0);
    send(hdp_pkg::k_mgmt_uc, 4'h0, 2'h0);
    chk("unreachable mgmt", 16'(n_drop), 16'h0001);
    chk("drop count", drop_cnt, 16'h0003);
  endtask

  task automatic t_desc;
    send(hdp_pkg::k_chan_desc, 4'h0, 2'h0);
    chk("chan desc copies", 16'(n_tx), 16'h0002);
    tx_is(0, 1'b1, 2'h0);
    tx_is(1, 1'b0, `HDP_PROF_COMMON);
    send(hdp_pkg::k_prof_desc, 4'h0, `HDP_PROF_COMMON);
    chk("common desc copies", 16'(n_tx), 16'h0002);
    tx_is(0, 1'b0, `HDP_PROF_COMMON);
    tx_is(1, 1'b1, 2'h0);
    send(hdp_pkg::k_prof_desc, 4'h0, `HDP_PROF_NEXT2);
    chk("desc copies", 16'(n_tx), 16'h0001);
    tx_is(0, 1'b0, `HDP_PROF_COMMON);
    chk("described id", 16'(tx_q[0].desc), 16'h0002);
  endtask

  task automatic t_chan;
    cfg(4'h2, 1'b0, 2'h0, 4'h7, `HDP_PROF_NEXT1);
    send(hdp_pkg::k_data, 4'h7, 2'h0, 1'h1);
    chk("other channel tx", 16'(n_tx), 16'h0001);
    chk("tx chan", 16'(tx_q[0].chan), 16'h0001);
    tx_is(0, 1'b0, `HDP_PROF_COMMON);
    for (int r = 0; r < 2; r++)
    begin
      send(hdp_pkg::k_data, 4'h7, 2'h0);
      chk("stream tx", 16'(n_tx), 16'h0001);
      tx_is(0, 1'b0, `HDP_PROF_NEXT1);
    end
  endtask

  // ==========================================================
  // sequence and verdict
  task automatic end_of_test;
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_profiles();
    t_refuse();
    t_mgmt();
    t_desc();
    t_chan();
    repeat (3) @(negedge clk);
    chk("modem forwarded", fwd, 16'h0007);
    chk("modem bad traffic", bad, 16'h0000);
    end_of_test();
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule
